// *** hdl/pdpsc_pkg.sv ***
/*
 * pdpsc_pkg: constants and carrier types for the powered-device power status
 * and startup controller.
 * Assumes a single 250 MHz core clock; analog comparators arrive as digital levels.
 */
package pdpsc_pkg;

    // ==========================================================================
    // timing
    // ==========================================================================
    localparam int CLK_MHZ = 250;
    localparam int MS_CYCLES = CLK_MHZ * 1000;
    localparam int IND_DELAY_MS = 24;
    localparam int BIAS_TIMEOUT_MS = 50;
    localparam int SRC_OFF_MS = 24;
    localparam int INRUSH_MIN_US = 81500;
    localparam int INRUSH_MIN_MS_X10 = 815;

    // ==========================================================================
    // pulse duty cycles, in thousandths of the pulse period
    // ==========================================================================
    localparam int DUTY_LOW_TYPE = 260;
    localparam int DUTY_SHORT = 125;
    localparam int DUTY_RES = 81;
    localparam int DUTY_OPEN = 54;
    localparam int DUTY_SCALE = 1000;
    localparam int PULSE_PERIOD_DEF = 250000;

    // ==========================================================================
    // indicator reset value (all released)
    // ==========================================================================
    localparam logic [2:0] IND_RESET = 3'h0;

    typedef enum logic [1:0] {
        PDPSC_DUTY_SHORT,
        PDPSC_DUTY_RES,
        PDPSC_DUTY_OPEN,
        PDPSC_DUTY_RSVD
    } pdpsc_duty_t;

    // pull-low enables of the three open-drain indicators
    typedef struct packed {
        logic upper;
        logic lower;
        logic highType;
    } pdpsc_ind_t;

    // analog comparator levels
    typedef struct packed {
        logic inputAbove32v;
        logic inputAboveMarkReset;
        logic inputAboveUvlo;
        logic thermalShutdown;
        logic biasAbove8v5;
        logic supplyAboveUvlo;
        logic loadBelow28ma;
        logic inrushCurrentLow;
    } pdpsc_sense_t;

endpackage : pdpsc_pkg

// *** hdl/pdpsc_ms_timer.sv ***
/*
 * pdpsc_ms_timer: counts ticks of a timebase enable (1 ms or 0.1 ms) while run is high.
 * Assumes tick is a one-cycle pulse on core_clk.
 */
module pdpsc_ms_timer
    import pdpsc_pkg::*;
#(
    parameter int WIDTH = 10
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic tick,
    input wire logic [WIDTH-1:0] limit,
    output logic done
);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic done_nxt;

    always_comb begin
        count_nxt = count_r;
        done_nxt = 1'b0;
        if (!run) begin
            count_nxt = '0;
        end else if (count_r >= limit) begin
            done_nxt = 1'b1;
        end else if (tick) begin
            count_nxt = count_r + WIDTH'(1);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
            done <= 1'b0;
        end else begin
            count_r <= count_nxt;
            done <= done_nxt & run;
        end
    end

endmodule // pdpsc_ms_timer

// *** hdl/pdpsc_ctrl.sv ***
/*
 * pdpsc_ctrl: indicator encoding, bias supply startup sequencing and
 * maintain-power-signature pulse generation for a powered device.
 * Assumes all inputs synchronous to core_clk; pins are open-drain, oe high = pull low.
 */
// Operation
// R1: allocated power follows received classification cycle count; indicators driven from it
// R2: high-type indicator low for type 3-4 source, released for type 1-2
// R3: one cycle both high; 2-3 lower low; 4 upper low; 5 both low
// R4: indicators show power actually allocated, not the class requested
// R5: indicators enabled 24 ms after bias-winding input rises
// R6: bias present before inrush end: 24 ms counted from inrush-done release
// R7: indicators released on thermal shutdown, supply undervoltage, or input below 32 V
// R8: indicator state kept above mark reset, reapplied after startup; cleared below it
// R9: startup current source turned on at end of inrush
// R10: bias switch closes when bias above 8.5 V or below it for 50 ms
// R11: startup source turned off 24 ms after bias switch closes
// R12: supply undervoltage reopens switch, restarts source, fresh startup cycle
// R13: select input chooses supply undervoltage threshold 6.9 V or 3.9 V
// R14: bias switch opens whenever input drops below undervoltage falling threshold
// R15: signature pulses generated while load return current below 28 mA
// R16: type 3-4 duty follows select pin: short 12.5, resistor 8.1, open 5.4
// R17: type 1-2 source uses fixed 26 percent duty, select pin ignored; code follows select pin while aux_adapter_detect is high
// R18: adapter detect: lower and high-type released, upper low, pulses enabled
// R19: inrush-done pulled low during inrush, released otherwise
// R20: inrush ends when current below 90 percent and 81.5 ms elapsed
// R21: indicator high is released open drain, low is pulled, one enable each
// R22: pulse period is a parameter; duty sets only the high fraction
module pdpsc_ctrl
    import pdpsc_pkg::*;
#(
    parameter int MS_TICKS = MS_CYCLES,
    parameter int PULSE_PERIOD = PULSE_PERIOD_DEF
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [2:0] classCycleCount,
    input wire logic classDone,
    input wire logic highTypeSource,
    input wire pdpsc_duty_t pulse_duty_select,
    input wire logic supply_undervoltage_select,
    input wire logic aux_adapter_detect,
    input wire pdpsc_sense_t sense,
    output pdpsc_ind_t indicatorOe,
    output logic inrush_done_out_oe,
    output logic startupSourceOn,
    output logic biasSwitchOn,
    output logic uvloSelectOut,
    output logic signature_pulse_drive
);

    if (MS_TICKS < 2 || PULSE_PERIOD < DUTY_SCALE) begin : g_bad_timebase
        $error("pdpsc_ctrl: timebase parameters too small");
    end

    localparam int INRUSH_TICKS_100US = INRUSH_MIN_MS_X10;
    localparam int SUB_TICKS = (MS_TICKS + 9) / 10;

    // ==========================================================================
    // timebase: 0.1 ms and 1 ms enables
    // ==========================================================================
    logic [31:0] subCnt_r, subCnt_nxt;
    logic [3:0] tenCnt_r, tenCnt_nxt;
    logic subTick_r, subTick_nxt;
    logic msTick_r, msTick_nxt;

    always_comb begin
        subCnt_nxt = subCnt_r + 32'h1;
        subTick_nxt = 1'b0;
        tenCnt_nxt = tenCnt_r;
        msTick_nxt = 1'b0;
        if (subCnt_r >= 32'(SUB_TICKS - 1)) begin
            subCnt_nxt = 32'h0;
            subTick_nxt = 1'b1;
            if (tenCnt_r == 4'h9) begin
                tenCnt_nxt = 4'h0;
                msTick_nxt = 1'b1;
            end else begin
                tenCnt_nxt = tenCnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            subCnt_r <= 32'h0;
            tenCnt_r <= 4'h0;
            subTick_r <= 1'b0;
            msTick_r <= 1'b0;
        end else begin
            subCnt_r <= subCnt_nxt;
            tenCnt_r <= tenCnt_nxt;
            subTick_r <= subTick_nxt;
            msTick_r <= msTick_nxt;
        end
    end

    // ==========================================================================
    // startup sequencer
    // ==========================================================================
    typedef enum logic [2:0] {
        ST_OFF,
        ST_INRUSH,
        ST_STARTUP,
        ST_BIAS_ON,
        ST_RUN
    } pdpsc_state_t;

    pdpsc_state_t state_r, state_nxt;
    logic inrushMinDone, biasTimeout, srcOffDone, indDelayDone;
    logic indDelayRun;
    logic powerOk;

    assign powerOk = sense.inputAboveUvlo && !sense.thermalShutdown && !aux_adapter_detect;

    pdpsc_ms_timer #(.WIDTH(10)) inrushTimer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .run(state_r == ST_INRUSH),
        .tick(subTick_r),
        .limit(10'(INRUSH_TICKS_100US)),
        .done(inrushMinDone)
    );

    pdpsc_ms_timer #(.WIDTH(10)) biasTimer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .run(state_r == ST_STARTUP && !sense.biasAbove8v5),
        .tick(msTick_r),
        .limit(10'(BIAS_TIMEOUT_MS)),
        .done(biasTimeout)
    );

    pdpsc_ms_timer #(.WIDTH(10)) srcTimer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .run(state_r == ST_BIAS_ON),
        .tick(msTick_r),
        .limit(10'(SRC_OFF_MS)),
        .done(srcOffDone)
    );

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OFF: begin
                if (powerOk) begin
                    state_nxt = ST_INRUSH;
                end
            end
            ST_INRUSH: begin
                if (sense.inrushCurrentLow && inrushMinDone) begin // R20
                    state_nxt = ST_STARTUP; // R9
                end
            end
            ST_STARTUP: begin
                if (sense.biasAbove8v5 || biasTimeout) begin // R10
                    state_nxt = ST_BIAS_ON;
                end
            end
            ST_BIAS_ON: begin
                if (srcOffDone) begin // R11
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
            end
        endcase
        if ((state_r == ST_BIAS_ON || state_r == ST_RUN) && !sense.supplyAboveUvlo) begin
            state_nxt = ST_STARTUP; // R12
        end
        if (!powerOk) begin
            state_nxt = ST_OFF; // R14
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================================
    // indicator memory and enable delay
    // ==========================================================================
    pdpsc_ind_t memInd_r, memInd_nxt;
    logic memValid_r, memValid_nxt;
    logic indEnable;

    // allocated power comes from cycle count alone, never from requested class
    function automatic pdpsc_ind_t encodeInd(input logic [2:0] cycles, input logic hiType);
        pdpsc_ind_t ind;
        ind.highType = hiType; // R2
        ind.upper = (cycles >= 3'h4); // R3
        ind.lower = (cycles == 3'h2) || (cycles == 3'h3) || (cycles == 3'h5); // R3
        return ind;
    endfunction

    always_comb begin
        memInd_nxt = memInd_r;
        memValid_nxt = memValid_r;
        if (classDone) begin
            memInd_nxt = encodeInd(classCycleCount, highTypeSource); // R1 R4
            memValid_nxt = 1'b1;
        end
        if (!sense.inputAboveMarkReset) begin
            memInd_nxt = IND_RESET; // R8
            memValid_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            memInd_r <= IND_RESET;
            memValid_r <= 1'b0;
        end else begin
            memInd_r <= memInd_nxt;
            memValid_r <= memValid_nxt;
        end
    end

    // delay starts once inrush is over and bias is high; covers both orders
    assign indDelayRun = (state_r == ST_STARTUP || state_r == ST_BIAS_ON || state_r == ST_RUN)
        && sense.biasAbove8v5; // R5 R6

    pdpsc_ms_timer #(.WIDTH(10)) indTimer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .run(indDelayRun),
        .tick(msTick_r),
        .limit(10'(IND_DELAY_MS)),
        .done(indDelayDone)
    );

    assign indEnable = indDelayDone && sense.inputAbove32v && !sense.thermalShutdown
        && sense.supplyAboveUvlo && memValid_r; // R7 R8

    // ==========================================================================
    // maintain-power-signature pulses
    // ==========================================================================
    logic [31:0] perCnt_r, perCnt_nxt;
    logic pulse_nxt;
    logic [31:0] highLen;
    logic pulseEnable;

    always_comb begin
        if (!highTypeSource && !aux_adapter_detect) begin
            highLen = 32'(PULSE_PERIOD / DUTY_SCALE * DUTY_LOW_TYPE); // R17
        end else begin
            unique case (pulse_duty_select) // R16
                PDPSC_DUTY_SHORT: highLen = 32'(PULSE_PERIOD / DUTY_SCALE * DUTY_SHORT);
                PDPSC_DUTY_RES: highLen = 32'(PULSE_PERIOD / DUTY_SCALE * DUTY_RES);
                default: highLen = 32'(PULSE_PERIOD / DUTY_SCALE * DUTY_OPEN);
            endcase
        end
    end

    assign pulseEnable = sense.loadBelow28ma && (state_r != ST_OFF || aux_adapter_detect); // R15 R18

    always_comb begin
        perCnt_nxt = perCnt_r + 32'h1; // R22
        if (perCnt_r >= 32'(PULSE_PERIOD - 1) || !pulseEnable) begin
            perCnt_nxt = 32'h0;
        end
        pulse_nxt = pulseEnable && (perCnt_nxt < highLen);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            perCnt_r <= 32'h0;
        end else begin
            perCnt_r <= perCnt_nxt;
        end
    end

    // ==========================================================================
    // registered outputs
    // ==========================================================================
    pdpsc_ind_t indOe_nxt;

    always_comb begin
        indOe_nxt = IND_RESET; // R21
        if (aux_adapter_detect) begin
            indOe_nxt.upper = 1'b1; // R18
        end else if (indEnable) begin
            indOe_nxt = memInd_r; // R21
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            indicatorOe <= IND_RESET;
            inrush_done_out_oe <= 1'b0;
            startupSourceOn <= 1'b0;
            biasSwitchOn <= 1'b0;
            uvloSelectOut <= 1'b0;
            signature_pulse_drive <= 1'b0;
        end else begin
            indicatorOe <= indOe_nxt;
            inrush_done_out_oe <= (state_nxt == ST_INRUSH); // R19
            startupSourceOn <= (state_nxt == ST_STARTUP || state_nxt == ST_BIAS_ON); // R9 R11
            biasSwitchOn <= (state_nxt == ST_BIAS_ON || state_nxt == ST_RUN); // R10 R12
            uvloSelectOut <= supply_undervoltage_select; // R13
            signature_pulse_drive <= pulse_nxt;
        end
    end

endmodule // pdpsc_ctrl

// *** sim/pdpsc_ctrl_properties.sv ***
/*
 * pdpsc_ctrl_properties: timing and level checks on the controller ports.
 * Assumes one core_clk domain and the async active-low reset_n.
 */
module pdpsc_ctrl_properties
    import pdpsc_pkg::*;
#(
    parameter int MS_TICKS = MS_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic supply_undervoltage_select,
    input wire logic aux_adapter_detect,
    input wire pdpsc_sense_t sense,
    input wire pdpsc_ind_t indicatorOe,
    input wire logic inrush_done_out_oe,
    input wire logic startupSourceOn,
    input wire logic biasSwitchOn,
    input wire logic uvloSelectOut,
    input wire logic signature_pulse_drive
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // cycle counters for inrush and closed switch
    // ==========================================================
    int inrCnt_r;
    int swCnt_r;
    int inrCnt_nxt;
    int swCnt_nxt;
    always_comb begin
        inrCnt_nxt = inrush_done_out_oe ? inrCnt_r + 1 : 0;
        swCnt_nxt = biasSwitchOn ? swCnt_r + 1 : 0;
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            inrCnt_r <= 0;
            swCnt_r <= 0;
        end else begin
            inrCnt_r <= inrCnt_nxt;
            swCnt_r <= swCnt_nxt;
        end
    end
    // ==========================================================
    // properties
    // ==========================================================
    property p_inrush_min;
        $fell(inrush_done_out_oe) && startupSourceOn
            |-> $past(sense.inrushCurrentLow)
            && inrCnt_r >= INRUSH_MIN_MS_X10 * MS_TICKS / 10 - MS_TICKS;
    endproperty
    a_inrush_min: assert property (p_inrush_min) else $error("inrush too short");
    property p_src_off;
        $fell(startupSourceOn) && biasSwitchOn |-> swCnt_r >= (SRC_OFF_MS - 1) * MS_TICKS
            && swCnt_r <= SRC_OFF_MS * MS_TICKS + 4;
    endproperty
    a_src_off: assert property (p_src_off) else $error("source off time wrong");
    property p_inrush_excl;
        inrush_done_out_oe |-> !startupSourceOn && !biasSwitchOn;
    endproperty
    a_inrush_excl: assert property (p_inrush_excl) else $error("supply on in inrush");
    property p_src_start;
        $rose(startupSourceOn) && !$past(biasSwitchOn) |-> $past(inrush_done_out_oe);
    endproperty
    a_src_start: assert property (p_src_start) else $error("source on outside inrush end");
    property p_sw_close;
        $rose(biasSwitchOn) |-> $past(startupSourceOn);
    endproperty
    a_sw_close: assert property (p_sw_close) else $error("switch closed without startup");
    property p_supply_uv;
        biasSwitchOn && !sense.supplyAboveUvlo |-> ##[1:3] !biasSwitchOn;
    endproperty
    a_supply_uv: assert property (p_supply_uv) else $error("switch kept on undervoltage");
    property p_input_uv;
        !sense.inputAboveUvlo |-> ##[1:3] !biasSwitchOn && !startupSourceOn;
    endproperty
    a_input_uv: assert property (p_input_uv) else $error("supply kept on input loss");
    property p_ind_off;
        (!aux_adapter_detect && (sense.thermalShutdown || !sense.inputAbove32v
            || !sense.supplyAboveUvlo))[*3] |-> indicatorOe == 3'h0;
    endproperty
    a_ind_off: assert property (p_ind_off) else $error("indicators not released");
    property p_aux;
        aux_adapter_detect[*3] |-> indicatorOe == 3'h4 && !inrush_done_out_oe;
    endproperty
    a_aux: assert property (p_aux) else $error("adapter indication wrong");
    property p_uv_sel;
        $past(reset_n) |-> uvloSelectOut == $past(supply_undervoltage_select);
    endproperty
    a_uv_sel: assert property (p_uv_sel) else $error("threshold select not passed");
    property p_mps_off;
        (!sense.loadBelow28ma)[*3] |-> !signature_pulse_drive;
    endproperty
    a_mps_off: assert property (p_mps_off) else $error("pulse under load");
endmodule // pdpsc_ctrl_properties

bind pdpsc_ctrl pdpsc_ctrl_properties #(.MS_TICKS(MS_TICKS)) pdpsc_ctrl_properties_i (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .supply_undervoltage_select(supply_undervoltage_select),
    .aux_adapter_detect(aux_adapter_detect),
    .sense(sense),
    .indicatorOe(indicatorOe),
    .inrush_done_out_oe(inrush_done_out_oe),
    .startupSourceOn(startupSourceOn),
    .biasSwitchOn(biasSwitchOn),
    .uvloSelectOut(uvloSelectOut),
    .signature_pulse_drive(signature_pulse_drive)
);

// *** sim/pdpsc_pse_model.sv ***
/*
 * pdpsc_pse_model: source equipment across the cable; class results, line levels.
 * Assumes its tasks are called just after a rising edge of core_clk.
 */
module pdpsc_pse_model
    import pdpsc_pkg::*;
(
    input wire logic core_clk,
    output logic [2:0] classCycleCount,
    output logic classDone,
    output logic highTypeSource,
    output logic lineOk,
    output logic markOk
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        classCycleCount = 3'h0;
        classDone = 1'b0;
        highTypeSource = 1'b0;
        lineOk = 1'b0;
        markOk = 1'b0;
    end
    // count lines show the inverse once the result is no longer valid
    task automatic classify(input logic [2:0] n, input logic t);
        classCycleCount = n;
        highTypeSource = t;
        classDone = 1'b1;
        @(posedge core_clk);
        #1;
        classDone = 1'b0;
        classCycleCount = ~n;
    endtask
    task automatic setPower(input logic on);
        lineOk = on;
        markOk = on;
    endtask
endmodule // pdpsc_pse_model

// *** sim/pdpsc_ctrl_bench.sv ***
/*
 * pdpsc_ctrl_bench: drives the controller through startup, encoding and pulses.
 * Assumes shortened ms tick of 100 cycles and a pulse period of 1000 cycles.
 */
module pdpsc_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import pdpsc_pkg::*;
    localparam int PER = 1000;
    logic core_clk, reset_n, classDone, highTypeSource, lineOk, markOk, usel, aux;
    logic above32, thermal, bias, supplyOk, lowLoad, inrLow;
    logic inrush_done_out_oe, startupSourceOn, biasSwitchOn, uvloSelectOut;
    logic signature_pulse_drive;
    logic [2:0] classCycleCount;
    pdpsc_duty_t duty;
    pdpsc_ind_t indicatorOe;
    pdpsc_sense_t sense;
    int fails, checks, n, h;
    int dutyExp[5] = '{DUTY_SHORT, DUTY_RES, DUTY_OPEN, DUTY_OPEN, DUTY_LOW_TYPE};
    assign sense = {above32, markOk, lineOk, thermal, bias, supplyOk, lowLoad, inrLow};
    pdpsc_pse_model pdpsc_pse_model_i (.core_clk(core_clk), .classCycleCount(classCycleCount),
        .classDone(classDone), .highTypeSource(highTypeSource), .lineOk(lineOk),
        .markOk(markOk));
    pdpsc_ctrl #(.MS_TICKS(100), .PULSE_PERIOD(PER)) pdpsc_ctrl_i (.core_clk(core_clk),
        .reset_n(reset_n), .classCycleCount(classCycleCount), .classDone(classDone),
        .highTypeSource(highTypeSource), .pulse_duty_select(duty),
        .supply_undervoltage_select(usel), .aux_adapter_detect(aux), .sense(sense),
        .indicatorOe(indicatorOe), .inrush_done_out_oe(inrush_done_out_oe),
        .startupSourceOn(startupSourceOn), .biasSwitchOn(biasSwitchOn),
        .uvloSelectOut(uvloSelectOut), .signature_pulse_drive(signature_pulse_drive));
    // ==========================================================
    // tasks
    // ==========================================================
    task automatic summarize();
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic cmpRange(input string what, input int lo, input int hi, input int got);
        checks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return inrush_done_out_oe;
            1: return biasSwitchOn;
            2: return startupSourceOn;
            3: return |indicatorOe;
            default: return signature_pulse_drive;
        endcase
    endfunction
    task automatic waitSig(input int k, input logic lvl, input int lim, output int c);
        c = 0;
        while (pick(k) !== lvl && c < lim) begin
            step(1);
            c++;
        end
        if (c >= lim) begin
            fails++;
            summarize();
        end
    endtask
    function automatic logic [2:0] enc(input int cyc, input int t);
        return {cyc >= 4, cyc == 2 || cyc == 3 || cyc == 5, t == 1};
    endfunction
    // ==========================================================
    // clock and sequence
    // ==========================================================
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        {reset_n, above32, thermal, bias, lowLoad, aux, usel, fails, checks} = '0;
        {supplyOk, inrLow} = 2'h3;
        duty = PDPSC_DUTY_SHORT;
        repeat (6) @(posedge core_clk);
        #1 reset_n = 1'b1;
        step(1);
        pdpsc_pse_model_i.setPower(1'b1);
        above32 = 1'b1;
        pdpsc_pse_model_i.classify(3'h4, 1'b1);
        step(2);
        cmp("inrush_oe", 1, inrush_done_out_oe);
        waitSig(0, 1'b0, 9000, n);
        cmpRange("inrush_len", 8130, 8165, n);
        cmp("src_sw", 2'h1, {biasSwitchOn, startupSourceOn});
        waitSig(1, 1'b1, 5200, n);
        cmpRange("bias_timeout", 4900, 5010, n);
        waitSig(2, 1'b0, 2600, n);
        cmpRange("src_off", 2300, 2410, n);
        cmp("ind_hold", 0, indicatorOe);
        bias = 1'b1;
        step(2250);
        cmp("ind_early", 0, indicatorOe);
        waitSig(3, 1'b1, 300, n);
        cmp("ind_on", enc(4, 1), indicatorOe);
        for (int k = 1; k < 11; k++) begin
            pdpsc_pse_model_i.classify(3'(k % 5 + 1), 1'(k / 6));
            step(3);
            cmp("ind_enc", enc(k % 5 + 1, k / 6), indicatorOe);
        end
        lowLoad = 1'b1;
        for (int d = 0; d < 5; d++) begin
            if (d == 4) pdpsc_pse_model_i.classify(3'h2, 1'b0);
            else duty = pdpsc_duty_t'(d);
            waitSig(4, 1'b0, 1100, n);
            waitSig(4, 1'b1, 1100, n);
            waitSig(4, 1'b0, 400, h);
            cmpRange("mps_high", PER / DUTY_SCALE * dutyExp[d] - 1,
                PER / DUTY_SCALE * dutyExp[d] + 1, h);
        end
        lowLoad = 1'b0;
        step(3);
        h = 0;
        repeat (1200) begin
            step(1);
            if (signature_pulse_drive !== 1'b0) h++;
        end
        cmp("mps_off", 0, h);
        pdpsc_pse_model_i.classify(3'h5, 1'b1);
        {supplyOk, bias} = 2'h0;
        step(3);
        cmp("uv_state", 3'h2, {biasSwitchOn, startupSourceOn, |indicatorOe});
        {supplyOk, bias} = 2'h3;
        waitSig(1, 1'b1, 20, n);
        usel = 1'b1;
        step(2);
        cmp("uv_sel", 1, uvloSelectOut);
        thermal = 1'b1;
        step(3);
        cmp("thermal", 0, {indicatorOe, biasSwitchOn, startupSourceOn});
        {thermal, inrLow} = 2'h0;
        waitSig(0, 1'b1, 10, n);
        step(8300);
        cmp("inrush_hold", 1, inrush_done_out_oe);
        inrLow = 1'b1;
        waitSig(0, 1'b0, 9000, n);
        waitSig(3, 1'b1, 2600, n);
        cmpRange("ind_restart", 2300, 2410, n);
        cmp("ind_kept", enc(5, 1), indicatorOe);
        above32 = 1'b0;
        step(3);
        cmp("ind_32v", 0, indicatorOe);
        above32 = 1'b1;
        pdpsc_pse_model_i.setPower(1'b0);
        step(3);
        cmp("pwr_off", 0, {biasSwitchOn, startupSourceOn});
        pdpsc_pse_model_i.setPower(1'b1);
        waitSig(0, 1'b1, 10, n);
        waitSig(0, 1'b0, 9000, n);
        step(2500);
        cmp("ind_cleared", 0, indicatorOe);
        aux = 1'b1;
        lowLoad = 1'b1;
        step(3);
        cmp("aux_ind", 4'h8, {indicatorOe, inrush_done_out_oe});
        waitSig(4, 1'b1, 1100, n);
        summarize();
    end
endmodule // pdpsc_ctrl_bench
